/* ocaux_pkg.sv */
// Package with register map, field layout, reset values and timing for the overcurrent and aux slice
package ocaux_pkg;
  localparam int         ADDR_W           = 8;
  localparam int         DATA_W           = 16;
  // Register offsets
  localparam logic [7:0] OFF_HIGH_LIMIT   = 8'h88;
  localparam logic [7:0] OFF_LOW_LIMIT    = 8'h89;
  localparam logic [7:0] OFF_CRC_SPARE    = 8'h8A;
  localparam logic [7:0] OFF_AUX_CFG1     = 8'h8B;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'hE0;
  localparam logic [7:0] OFF_IRQ_MASK     = 8'hE1;
  localparam logic [7:0] OFF_STATUS       = 8'hE2;
  localparam logic [7:0] OFF_SEQ_STEP     = 8'hE3;
  // Reset values
  localparam logic [15:0] RST_HIGH_LIMIT  = 16'h7FFF;
  localparam logic [15:0] RST_LOW_LIMIT   = 16'h8000;
  localparam logic [15:0] RST_CRC_SPARE   = 16'h5555;
  localparam logic [15:0] RST_AUX_CFG1    = 16'h8010;
  localparam logic [15:0] RST_IRQ_MASK    = 16'h0000;
  // Detection-off codes
  localparam logic [15:0] HIGH_OFF_CODE   = 16'h7FFF;
  localparam logic [15:0] LOW_OFF_CODE    = 16'h8000;
  // Aux config field positions
  localparam int         CFG_ON_BIT       = 15;
  localparam int         CFG_VCM_BIT      = 10;
  localparam int         CFG_SRC_MUX_HI   = 9;
  localparam int         CFG_SRC_MUX_LO   = 7;
  localparam int         CFG_SNK_MUX_HI   = 6;
  localparam int         CFG_SNK_MUX_LO   = 4;
  localparam int         CFG_SRC_LVL_HI   = 3;
  localparam int         CFG_SRC_LVL_LO   = 2;
  localparam int         CFG_SNK_LVL_HI   = 1;
  localparam int         CFG_SNK_LVL_LO   = 0;
  localparam logic [15:0] CFG_WR_MASK     = 16'h87FF;
  // Interrupt status bits
  localparam int         IRQ_HIGH_BIT     = 0;
  localparam int         IRQ_LOW_BIT      = 1;
  localparam int         IRQ_AUX_OFF_BIT  = 2;
  localparam int         IRQ_W            = 3;
  // Fast filter
  localparam int         FAST_OSR         = 64;
  localparam int         FAST_ORDER       = 3;
  // Extra bit keeps the positive full-scale sum from wrapping
  localparam int         FAST_ACC_W       = 2 + FAST_ORDER * 6;
  localparam logic [5:0] FAST_OSR_LAST    = 6'h3F;
  // Sample rate of the modulator: fast clock divided down
  localparam int         MOD_DIV          = 25;
  localparam logic [4:0] MOD_DIV_LAST     = 5'(MOD_DIV - 1);
endpackage

/* ocaux_sinc3.sv */
// Third-order sinc decimator with a fixed ratio of 64, giving a signed 16-bit result
`timescale 1ns/10ps
module ocaux_sinc3 (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Modulator stream
  input  wire logic        bit_en,
  input  wire logic        mod_bit,
  // Filter result
  output logic [15:0]      fast_result,
  output logic             fast_valid
);
  localparam int AW = ocaux_pkg::FAST_ACC_W;
  logic signed [AW-1:0] int1_r, int2_r, int3_r;
  logic signed [AW-1:0] d1_r, d2_r, d3_r;
  logic signed [AW-1:0] c1, c2, c3;
  logic [5:0]           phase_r;
  logic signed [AW-1:0] x_in;

  assign x_in = mod_bit ? AW'(1) : -AW'(1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int1_r  <= '0;
      int2_r  <= '0;
      int3_r  <= '0;
      phase_r <= '0;
    end else if (bit_en) begin
      int1_r  <= int1_r + x_in;
      int2_r  <= int2_r + int1_r;
      int3_r  <= int3_r + int2_r;
      phase_r <= phase_r + 6'h01;
    end
  end

  assign c1 = int3_r - d1_r;
  assign c2 = c1 - d2_r;
  assign c3 = c2 - d3_r;

  // Comb stages run once per 64 modulator bits; full scale 2^18 is shifted down by 3 and saturated
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      d1_r        <= '0;
      d2_r        <= '0;
      d3_r        <= '0;
      fast_result <= 16'h0000;
      fast_valid  <= 1'b0;
    end else begin
      fast_valid <= 1'b0;
      if (bit_en && phase_r == ocaux_pkg::FAST_OSR_LAST) begin
        d1_r        <= int3_r;
        d2_r        <= c1;
        d3_r        <= c2;
        fast_result <= (c3 >= AW'(32'sh40000)) ? 16'h7FFF : c3[AW-2:AW-17];
        fast_valid  <= 1'b1;
      end
    end
  end
endmodule

/* ocaux_trip.sv */
// Signed threshold comparator pair with disable codes
`timescale 1ns/10ps
module ocaux_trip (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Filter result and limits
  input  wire logic [15:0] fast_result,
  input  wire logic        fast_valid,
  input  wire logic [15:0] high_trip_level,
  input  wire logic [15:0] low_trip_level,
  // Trip events
  output logic             high_trip_event,
  output logic             low_trip_event
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      high_trip_event <= 1'b0;
      low_trip_event  <= 1'b0;
    end else if (fast_valid) begin
      high_trip_event <= (high_trip_level != ocaux_pkg::HIGH_OFF_CODE) &&
                         ($signed(fast_result) > $signed(high_trip_level));
      low_trip_event  <= (low_trip_level != ocaux_pkg::LOW_OFF_CODE) &&
                         ($signed(fast_result) < $signed(low_trip_level));
    end
  end
endmodule

/* ocaux_regs.sv */
// Overcurrent thresholds, CRC spare and aux converter first config register, with trip logic
//
// Summary of operation
// - High event when fast filter result exceeds signed high threshold.
// - High threshold at maximum positive code disables high detection.
// - Low event when fast filter result is below signed low threshold.
// - Low threshold at most negative code disables low detection.
// - Thresholds are 16-bit two's complement, same scale as filter output.
// - Spare register stores written value, no effect, feeds map CRC.
// - Bit 15 turns aux converter on; resets enabled.
// - Aux off or standby clears aux results and sequence counter.
// - Bit 10 enables common-mode buffer on analog input seven; resets off.
// - Bits 9:7 route open-wire source to input index; resets 0.
// - Bits 6:4 route open-wire sink to input index; resets 1.
// - Bits 3:2 source magnitude: off, 4, 40, 240 microamps.
// - Bits 1:0 sink magnitude, same encoding as source.
// - Fault output high while either trip event is active.
// - Compare against sinc3 fast filter, fixed ratio 64.
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
module ocaux_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // Current converter one modulator stream
  input  wire logic        mod_bit,
  // Device power state
  input  wire logic        standby_or_powerdown,
  // Aux converter results from the analog side
  input  wire logic [15:0] aux_sample,
  input  wire logic        aux_sample_valid,
  // Overcurrent outputs
  output logic             high_trip_event,
  output logic             low_trip_event,
  output logic             overcurrent_fault_out,
  // Aux converter controls
  output logic             aux_converter_on,
  output logic             aux_run,
  output logic             common_mode_buffer_on,
  output logic [2:0]       open_wire_source_route,
  output logic [2:0]       open_wire_sink_route,
  output logic [1:0]       open_wire_source_level,
  output logic [1:0]       open_wire_sink_level,
  output logic [15:0]      aux_result,
  output logic [1:0]       sequence_step_counter,
  // Register map CRC feed
  output logic [15:0]      crc_spare_value,
  // Interrupt
  output logic             irq
);
  logic [15:0]  high_limit_r;
  logic [15:0]  low_limit_r;
  logic [15:0]  spare_r;
  logic [15:0]  cfg1_r;
  logic [2:0]   irq_stat_r;
  logic [2:0]   irq_mask_r;
  logic [2:0]   irq_set;
  logic [2:0]   irq_clr;
  logic         high_d_r;
  logic         low_d_r;
  logic         aux_on_d_r;
  logic [4:0]   div_r;
  logic         bit_en;
  logic [15:0]  fast_result;
  logic         fast_valid;
  logic [15:0]  rd_nxt;
  logic         wr_high;
  logic         wr_low;
  logic         wr_spare;
  logic         wr_cfg;
  logic         wr_mask;
  logic         wr_stat;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Write strobes, one per writable register
  assign wr_high  = reg_wr && hit(reg_addr, ocaux_pkg::OFF_HIGH_LIMIT);
  assign wr_low   = reg_wr && hit(reg_addr, ocaux_pkg::OFF_LOW_LIMIT);
  assign wr_spare = reg_wr && hit(reg_addr, ocaux_pkg::OFF_CRC_SPARE);
  assign wr_cfg   = reg_wr && hit(reg_addr, ocaux_pkg::OFF_AUX_CFG1);
  assign wr_mask  = reg_wr && hit(reg_addr, ocaux_pkg::OFF_IRQ_MASK);
  assign wr_stat  = reg_wr && hit(reg_addr, ocaux_pkg::OFF_IRQ_STATUS);

  // High threshold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      high_limit_r <= ocaux_pkg::RST_HIGH_LIMIT;
    end else if (wr_high) begin
      high_limit_r <= reg_wdata;
    end
  end

  // Low threshold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_limit_r <= ocaux_pkg::RST_LOW_LIMIT;
    end else if (wr_low) begin
      low_limit_r <= reg_wdata;
    end
  end

  // Spare word, no effect beyond the CRC feed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spare_r <= ocaux_pkg::RST_CRC_SPARE;
    end else if (wr_spare) begin
      spare_r <= reg_wdata;
    end
  end

  // Aux config; reserved bits are dropped on write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg1_r <= ocaux_pkg::RST_AUX_CFG1;
    end else if (wr_cfg) begin
      cfg1_r <= reg_wdata & ocaux_pkg::CFG_WR_MASK;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_r <= ocaux_pkg::RST_IRQ_MASK[2:0];
    end else if (wr_mask) begin
      irq_mask_r <= reg_wdata[2:0];
    end
  end

  // Read data registered, one cycle after the strobe; unmapped reads return zero
  always_comb begin
    rd_nxt = 16'h0000;
    if (hit(reg_addr, ocaux_pkg::OFF_HIGH_LIMIT)) begin
      rd_nxt = high_limit_r;
    end else if (hit(reg_addr, ocaux_pkg::OFF_LOW_LIMIT)) begin
      rd_nxt = low_limit_r;
    end else if (hit(reg_addr, ocaux_pkg::OFF_CRC_SPARE)) begin
      rd_nxt = spare_r;
    end else if (hit(reg_addr, ocaux_pkg::OFF_AUX_CFG1)) begin
      rd_nxt = cfg1_r;
    end else if (hit(reg_addr, ocaux_pkg::OFF_IRQ_STATUS)) begin
      rd_nxt = {13'h0000, irq_stat_r};
    end else if (hit(reg_addr, ocaux_pkg::OFF_IRQ_MASK)) begin
      rd_nxt = {13'h0000, irq_mask_r};
    end else if (hit(reg_addr, ocaux_pkg::OFF_STATUS)) begin
      rd_nxt = {13'h0000, aux_run, low_trip_event, high_trip_event};
    end else if (hit(reg_addr, ocaux_pkg::OFF_SEQ_STEP)) begin
      rd_nxt = {14'h0000, sequence_step_counter};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Config fields out
  assign aux_converter_on       = cfg1_r[ocaux_pkg::CFG_ON_BIT];
  assign common_mode_buffer_on  = cfg1_r[ocaux_pkg::CFG_VCM_BIT];
  assign open_wire_source_route = cfg1_r[ocaux_pkg::CFG_SRC_MUX_HI:ocaux_pkg::CFG_SRC_MUX_LO];
  assign open_wire_sink_route   = cfg1_r[ocaux_pkg::CFG_SNK_MUX_HI:ocaux_pkg::CFG_SNK_MUX_LO];
  assign open_wire_source_level = cfg1_r[ocaux_pkg::CFG_SRC_LVL_HI:ocaux_pkg::CFG_SRC_LVL_LO];
  assign open_wire_sink_level   = cfg1_r[ocaux_pkg::CFG_SNK_LVL_HI:ocaux_pkg::CFG_SNK_LVL_LO];
  assign crc_spare_value        = spare_r;
  assign aux_run                = aux_converter_on && !standby_or_powerdown;

  // Aux result; cleared while the converter is not running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aux_result <= 16'h0000;
    end else if (!aux_run) begin
      aux_result <= 16'h0000;
    end else if (aux_sample_valid) begin
      aux_result <= aux_sample;
    end
  end

  // Sequence step counter; cleared while the converter is not running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sequence_step_counter <= 2'b00;
    end else if (!aux_run) begin
      sequence_step_counter <= 2'b00;
    end else if (aux_sample_valid) begin
      sequence_step_counter <= sequence_step_counter + 2'b01;
    end
  end

  // Modulator bit rate enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= 5'h00;
    end else if (div_r == ocaux_pkg::MOD_DIV_LAST) begin
      div_r <= 5'h00;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end
  assign bit_en = (div_r == ocaux_pkg::MOD_DIV_LAST);

  ocaux_sinc3 u_fast (
    .clk         (clk),
    .rstn        (rstn),
    .bit_en      (bit_en),
    .mod_bit     (mod_bit),
    .fast_result (fast_result),
    .fast_valid  (fast_valid)
  );

  ocaux_trip u_trip (
    .clk             (clk),
    .rstn            (rstn),
    .fast_result     (fast_result),
    .fast_valid      (fast_valid),
    .high_trip_level (high_limit_r),
    .low_trip_level  (low_limit_r),
    .high_trip_event (high_trip_event),
    .low_trip_event  (low_trip_event)
  );

  assign overcurrent_fault_out = high_trip_event | low_trip_event;

  // Interrupts: rising edges of trip events and aux converter stopping
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      high_d_r <= 1'b0;
    end else begin
      high_d_r <= high_trip_event;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_d_r <= 1'b0;
    end else begin
      low_d_r <= low_trip_event;
    end
  end

  // Only a fall is flagged, so the low reset value cannot fake one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aux_on_d_r <= 1'b0;
    end else begin
      aux_on_d_r <= aux_run;
    end
  end

  assign irq_set = {aux_on_d_r & ~aux_run, low_trip_event & ~low_d_r, high_trip_event & ~high_d_r};
  assign irq_clr = wr_stat ? reg_wdata[2:0] : 3'h0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= 3'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);
endmodule

/* ocaux_regs_checker.sv */
// Concurrent checks on the ports of the overcurrent and aux register slice
`timescale 1ns/10ps
module ocaux_regs_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Power state
  input wire logic        standby_or_powerdown,
  // Observed outputs
  input wire logic        high_trip_event,
  input wire logic        low_trip_event,
  input wire logic        overcurrent_fault_out,
  input wire logic        aux_converter_on,
  input wire logic        aux_run,
  input wire logic [2:0]  open_wire_source_route,
  input wire logic [2:0]  open_wire_sink_route,
  input wire logic [15:0] aux_result,
  input wire logic [1:0]  sequence_step_counter,
  input wire logic [15:0] crc_spare_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [15:0] hi_r;
  logic [15:0] lo_r;
  // Shadow copies of the two limits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_r <= ocaux_pkg::RST_HIGH_LIMIT;
      lo_r <= ocaux_pkg::RST_LOW_LIMIT;
    end else if (reg_wr && reg_addr == ocaux_pkg::OFF_HIGH_LIMIT) begin
      hi_r <= reg_wdata;
    end else if (reg_wr && reg_addr == ocaux_pkg::OFF_LOW_LIMIT) begin
      lo_r <= reg_wdata;
    end
  end
  property p_fault; overcurrent_fault_out == (high_trip_event || low_trip_event); endproperty
  a_fault: assert property (p_fault) else $error("fault output differs from event OR");
  property p_high_off; $rose(high_trip_event) |-> $past(hi_r) != 16'h7FFF; endproperty
  a_high_off: assert property (p_high_off) else $error("high event while detection off");
  property p_low_off; $rose(low_trip_event) |-> $past(lo_r) != 16'h8000; endproperty
  a_low_off: assert property (p_low_off) else $error("low event while detection off");
  property p_rd_high; reg_rd && reg_addr == ocaux_pkg::OFF_HIGH_LIMIT |=> reg_rdata == hi_r; endproperty
  a_rd_high: assert property (p_rd_high) else $error("high limit readback wrong");
  property p_rd_spare; reg_rd && reg_addr == ocaux_pkg::OFF_CRC_SPARE |=> reg_rdata == crc_spare_value; endproperty
  a_rd_spare: assert property (p_rd_spare) else $error("spare readback differs from crc feed");
  property p_rsv;
    reg_rd && reg_addr == ocaux_pkg::OFF_AUX_CFG1 |=> reg_rdata[14:11] == 4'h0 && reg_rdata[15] == aux_converter_on;
  endproperty
  a_rsv: assert property (p_rsv) else $error("config readback wrong");
  property p_cfg;
    reg_wr && reg_addr == ocaux_pkg::OFF_AUX_CFG1 |=> {aux_converter_on, open_wire_source_route, open_wire_sink_route}
      == {$past(reg_wdata[15]), $past(reg_wdata[9:7]), $past(reg_wdata[6:4])};
  endproperty
  a_cfg: assert property (p_cfg) else $error("config fields not updated");
  property p_clr; !aux_run |=> aux_result == 16'h0000 && sequence_step_counter == 2'h0; endproperty
  a_clr: assert property (p_clr) else $error("aux results not cleared");
  property p_run; standby_or_powerdown |-> !aux_run; endproperty
  a_run: assert property (p_run) else $error("aux runs in standby");
  c_high: cover property ($rose(high_trip_event));
  c_low: cover property ($rose(low_trip_event));
  c_sb: cover property ($rose(standby_or_powerdown) && aux_converter_on);
endmodule

/* ocaux_afe_model.sv */
// Analog side model: modulator stream of chosen density and aux samples
`timescale 1ns/10ps
module ocaux_afe_model (
  // Clock
  input  wire logic       clk,
  // Control from bench
  input  wire logic [3:0] dens,
  input  wire logic       aux_go,
  // Outputs to the block
  output logic            mod_bit,
  output logic [15:0]     aux_sample,
  output logic            aux_sample_valid
);
  logic [2:0] cnt_r = 3'h0;
  // Ones per eight cycles; the divide by 25 walks every phase
  always_ff @(posedge clk) begin
    cnt_r            <= cnt_r + 3'h1;
    mod_bit          <= ({1'b0, cnt_r} < dens);
    aux_sample_valid <= aux_go;
    aux_sample       <= aux_go ? 16'h3C5A : ~aux_sample;
  end
endmodule

/* overcurrent_aux_adc_regs_bench.sv */
// Self-checking bench for the overcurrent and aux register slice
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module overcurrent_aux_adc_regs_bench;
  typedef struct packed {logic w; logic [7:0] a; logic [15:0] d;} ocaux_row_t;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        standby_or_powerdown = 1'b0;
  logic        aux_go = 1'b0;
  logic [3:0]  dens = 4'h8;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, aux_sample, aux_result, crc_spare_value, v;
  logic        mod_bit, aux_sample_valid, high_trip_event, low_trip_event, overcurrent_fault_out;
  logic        aux_converter_on, aux_run, common_mode_buffer_on, irq;
  logic [2:0]  open_wire_source_route, open_wire_sink_route;
  logic [1:0]  open_wire_source_level, open_wire_sink_level, sequence_step_counter;
  int          errors = 0;
  int          checks_done = 0;
  ocaux_row_t  rows [11] = '{
    '{1'b0, 8'h88, 16'h7FFF}, '{1'b0, 8'h89, 16'h8000}, '{1'b0, 8'h8A, 16'h5555},
    '{1'b0, 8'h8B, 16'h8010}, '{1'b0, 8'hE1, 16'h0000}, '{1'b0, 8'h10, 16'h0000},
    '{1'b1, 8'h8A, 16'hA5C3}, '{1'b0, 8'h8A, 16'hA5C3}, '{1'b1, 8'h8B, 16'hFFFF},
    '{1'b0, 8'h8B, 16'h87FF}, '{1'b1, 8'h8B, 16'h0010}};
  ocaux_afe_model ocaux_afe_model_inst (.clk(clk), .dens(dens), .aux_go(aux_go), .mod_bit(mod_bit),
    .aux_sample(aux_sample), .aux_sample_valid(aux_sample_valid));
  ocaux_regs ocaux_regs_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_bit(mod_bit), .standby_or_powerdown(standby_or_powerdown),
    .aux_sample(aux_sample), .aux_sample_valid(aux_sample_valid), .high_trip_event(high_trip_event),
    .low_trip_event(low_trip_event), .overcurrent_fault_out(overcurrent_fault_out),
    .aux_converter_on(aux_converter_on), .aux_run(aux_run), .common_mode_buffer_on(common_mode_buffer_on),
    .open_wire_source_route(open_wire_source_route), .open_wire_sink_route(open_wire_sink_route),
    .open_wire_source_level(open_wire_source_level), .open_wire_sink_level(open_wire_sink_level),
    .aux_result(aux_result), .sequence_step_counter(sequence_step_counter), .crc_spare_value(crc_spare_value),
    .irq(irq));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a, v);
        `CHK("row read", rows[i].d, v)
      end
    end
    `CHK("crc feed", 16'hA5C3, crc_spare_value)
    $display("register table done");
    // Aux is off here, so config changes are legal
    for (int i = 0; i < 8; i++) begin
      wr(8'h8B, 16'(((i % 2) << 10) | (i << 7) | ((7 - i) << 4) | ((i % 4) << 2) | (3 - i % 4)));
      #1;
      `CHK("vcm", 1'(i % 2), common_mode_buffer_on)
      `CHK("src route", 3'(i), open_wire_source_route)
      `CHK("snk route", 3'(7 - i), open_wire_sink_route)
      `CHK("src level", 2'(i % 4), open_wire_source_level)
      `CHK("snk level", 2'(3 - i % 4), open_wire_sink_level)
    end
    $display("config fields done");
    wr(8'hE1, 16'h0007);
    wr(8'h88, 16'h7FFE);
    wr(8'h89, 16'h0000);
    repeat (6000) @(posedge clk);
    #1;
    `CHK("high event", 1'b1, high_trip_event)
    `CHK("low quiet", 1'b0, low_trip_event)
    `CHK("fault", 1'b1, overcurrent_fault_out)
    wr(8'h88, 16'h7FFF);
    repeat (1700) @(posedge clk);
    #1;
    `CHK("high off", 1'b0, high_trip_event)
    dens <= 4'h3;
    repeat (6000) @(posedge clk);
    #1;
    `CHK("low event", 1'b1, low_trip_event)
    `CHK("fault low", 1'b1, overcurrent_fault_out)
    rd(8'hE2, v);
    `CHK("status reg", 16'h0002, v)
    wr(8'h89, 16'h8000);
    repeat (1700) @(posedge clk);
    #1;
    `CHK("low off", 1'b0, low_trip_event)
    `CHK("fault off", 1'b0, overcurrent_fault_out)
    `CHK("irq set", 1'b1, irq)
    rd(8'hE0, v);
    `CHK("irq status", 16'h0007, v)
    wr(8'hE1, 16'h0000);
    `CHK("irq masked", 1'b0, irq)
    wr(8'hE1, 16'h0007);
    wr(8'hE0, 16'h0007);
    `CHK("irq cleared", 1'b0, irq)
    $display("trip path done");
    wr(8'h8B, 16'h8010);
    `CHK("aux run", 1'b1, aux_run)
    for (int i = 0; i < 3; i++) begin
      aux_go <= 1'b1;
      @(posedge clk);
      aux_go <= 1'b0;
      @(posedge clk);
    end
    @(posedge clk);
    #1;
    `CHK("seq count", 2'h3, sequence_step_counter)
    `CHK("aux data", 16'h3C5A, aux_result)
    rd(8'hE3, v);
    `CHK("seq reg", 16'h0003, v)
    standby_or_powerdown <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("sb data", 16'h0000, aux_result)
    `CHK("sb count", 2'h0, sequence_step_counter)
    wr(8'hE0, 16'h0004);
    `CHK("irq sb clear", 1'b0, irq)
    standby_or_powerdown <= 1'b0;
    aux_go <= 1'b1;
    @(posedge clk);
    aux_go <= 1'b0;
    wr(8'h8B, 16'h0010);
    @(posedge clk);
    #1;
    `CHK("off data", 16'h0000, aux_result)
    `CHK("off count", 2'h0, sequence_step_counter)
    `CHK("irq aux off", 1'b1, irq)
    $display("aux clear done");
    final_report();
  end
endmodule
bind ocaux_regs ocaux_regs_checker ocaux_regs_checker_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .standby_or_powerdown(standby_or_powerdown), .high_trip_event(high_trip_event), .low_trip_event(low_trip_event),
  .overcurrent_fault_out(overcurrent_fault_out), .aux_converter_on(aux_converter_on), .aux_run(aux_run),
  .open_wire_source_route(open_wire_source_route), .open_wire_sink_route(open_wire_sink_route),
  .aux_result(aux_result), .sequence_step_counter(sequence_step_counter), .crc_spare_value(crc_spare_value));
